// >>> dsp_pkg.sv
/*
 Constants, command codes and states of the digital potentiometer serial
 command port. Assumes a 100 MHz system clock sampling the serial pins.
*/
package dsp_pkg;
   localparam int          FRAME_BITS      = 16;
   localparam int          DATA_BITS       = 10;
   localparam int          CMD_MSB         = 13;
   localparam int          CMD_LSB         = 10;
   localparam int          FUSE_DEPTH      = 20;
   localparam int          FUSE_ADDR_BITS  = 5;
   localparam logic [9:0]  WIPER_MIDSCALE  = 10'h200;
   localparam logic [9:0]  LOW_RES_MASK    = 10'h3FC;
   localparam bit          LOW_RES         = 1'b0;
   localparam logic [3:0]  CTRL_RESET      = 4'h0;
   localparam int          CTRL_FUSE_EN    = 0;
   localparam int          CTRL_WR_EN      = 1;
   localparam int          CTRL_CAL        = 2;
   localparam int          CTRL_OK         = 3;
   localparam logic [4:0]  STATUS_ADDR_LO  = 5'h14;
   localparam logic [4:0]  STATUS_ADDR_HI  = 5'h15;
   localparam logic [3:0]  CMD_NO_OPERATION = 4'h0;
   localparam logic [3:0]  CMD_WR_WIPER    = 4'h1;
   localparam logic [3:0]  CMD_RD_WIPER    = 4'h2;
   localparam logic [3:0]  CMD_STORE       = 4'h3;
   localparam logic [3:0]  CMD_REFRESH     = 4'h4;
   localparam logic [3:0]  CMD_RD_FUSE     = 4'h5;
   localparam logic [3:0]  CMD_WR_CTRL     = 4'h6;
   localparam logic [3:0]  CMD_RD_CTRL     = 4'h7;
   localparam logic [3:0]  CMD_SHUTDOWN    = 4'h8;
   localparam int          CLK_MHZ         = 100;
   localparam int          FUSE_PROG_US    = 8000;
   localparam int          FUSE_PROG_CYCLES = FUSE_PROG_US * CLK_MHZ;
   typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_LOCK} dsp_state_e;
endpackage

// >>> dsp_fuse_if.sv
/*
 Carrier between the command decoder and the fuse memory.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface dsp_fuse_if;
   logic        store;
   logic [9:0]  store_data;
   logic [4:0]  rd_addr;
   logic [9:0]  rd_data;
   logic [9:0]  last_value;
   logic        busy;
   logic        done;
   logic        ok;
   modport ctrl (output store, store_data, rd_addr,
                 input  rd_data, last_value, busy, done, ok);
   modport mem  (input  store, store_data, rd_addr,
                 output rd_data, last_value, busy, done, ok);
endinterface

// >>> dsp_pin_sync.sv
/*
 Two-flop synchronisers for the serial pins, one per bit.
 Assumes the pins are asynchronous to the system clock.
*/
`timescale 1ns/1ps
module dsp_pin_sync #(
   parameter int         W         = 3,
   parameter logic [2:0] RESET_VAL = 3'h0
) (
   input  wire logic         clk_sys_i,
   input  wire logic         reset_n_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] meta_reg;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
         if (!reset_n_i) begin
            meta_reg[i] <= RESET_VAL[i];
            level_o[i]  <= RESET_VAL[i];
         end else begin
            meta_reg[i] <= pin_i[i];
            level_o[i]  <= meta_reg[i];
         end
      end
   end
endmodule

// >>> dsp_fuse_mem.sv
/*
 One-time-programmable wiper store of twenty locations with a program timer.
 Assumes the caller only requests a store while busy is low.
*/
`timescale 1ns/1ps
module dsp_fuse_mem
   import dsp_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = FUSE_PROG_CYCLES
) (
   input  wire logic clk_sys_i,
   input  wire logic reset_n_i,
   dsp_fuse_if.mem   fuse
);
   logic [9:0]  mem_array [FUSE_DEPTH];
   logic [4:0]  count_reg;
   logic [31:0] timer_reg;
   logic [9:0]  pend_reg;
   logic        busy_reg;
   logic        done_reg;
   logic        ok_reg;
   logic [4:0]  hi_cnt;

   // Count of programmed locations is reset here; a real fuse would keep it
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         count_reg <= 5'h00;
         timer_reg <= 32'h0;
         pend_reg  <= 10'h000;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
         ok_reg    <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (fuse.store && !busy_reg) begin
            if (count_reg < 5'(FUSE_DEPTH)) begin
               busy_reg  <= 1'b1;
               timer_reg <= PROG_CYCLES - 1;
               pend_reg  <= fuse.store_data;
            end else begin
               done_reg <= 1'b1;
               ok_reg   <= 1'b0;
            end
         end else if (busy_reg) begin
            if (timer_reg == 32'h0) begin
               busy_reg  <= 1'b0;
               done_reg  <= 1'b1;
               ok_reg    <= 1'b1;
               count_reg <= count_reg + 5'h01;
            end else begin
               timer_reg <= timer_reg - 32'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (busy_reg && timer_reg == 32'h0) begin
         mem_array[count_reg] <= pend_reg;
      end
   end

   assign hi_cnt = (count_reg > 5'h0A) ? count_reg - 5'h0A : 5'h00;

   always_comb begin
      if (fuse.rd_addr == STATUS_ADDR_LO) begin
         fuse.rd_data = (count_reg >= 5'h0A) ? 10'h3FF :
                        10'((11'h001 << count_reg) - 11'h001);
      end else if (fuse.rd_addr == STATUS_ADDR_HI) begin
         fuse.rd_data = 10'((11'h001 << hi_cnt) - 11'h001);
      end else if (fuse.rd_addr < count_reg) begin
         fuse.rd_data = mem_array[fuse.rd_addr];
      end else begin
         fuse.rd_data = 10'h000;
      end
   end

   assign fuse.last_value = (count_reg == 5'h00) ? WIPER_MIDSCALE
                            : mem_array[count_reg - 5'h01];
   assign fuse.busy = busy_reg;
   assign fuse.done = done_reg;
   assign fuse.ok   = ok_reg;
endmodule

// >>> dsp_serial_port.sv
/*
 Serial command port of a digital potentiometer: frame capture, command
 decode, wiper, control and shutdown state, readback and open-drain pins.
 Assumes the host drives frame select, serial clock and data in, with a
 serial clock much slower than the system clock (eight samples or more).
*/
`timescale 1ns/1ps
module dsp_serial_port
   import dsp_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = FUSE_PROG_CYCLES
) (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic        frame_select_n_i,
   input  wire logic        serial_clk_i,
   input  wire logic        serial_in_i,
   input  wire logic        serial_out_i,
   output logic             serial_out_o,
   output logic             serial_out_oe_n_o,
   input  wire logic        ready_i,
   output logic             ready_o,
   output logic             ready_oe_n_o,
   output logic [9:0]       wiper_position_o,
   output logic [3:0]       control_flags_o,
   output logic             shutdown_o,
   output logic             calibration_select_o
);
   dsp_fuse_if fuse ();

   logic [2:0]      pins_s;
   logic            fs_n_s;
   logic            sclk_s;
   logic            din_s;
   logic            fs_prev_reg;
   logic            sclk_prev_reg;
   logic            fs_fall;
   logic            fs_rise;
   logic            sclk_fall;

   dsp_state_e      state_reg;
   dsp_state_e      state_next;
   logic [15:0]     shift_reg;
   logic [3:0]      bit_cnt_reg;
   logic            full_frame_reg;
   logic            frame_ok;
   logic            exec;
   logic [3:0]      cmd;
   logic [9:0]      data;
   logic [9:0]      wiper_reg;
   logic [3:0]      ctrl_reg;
   logic            shutdown_reg;
   logic            store_reg;
   logic [9:0]      store_data_reg;
   logic [4:0]      rd_addr_reg;
   logic            fuse_load_reg;
   logic            dout_oe_n_reg;
   logic            ready_oe_n_reg;
   logic [9:0]      res_mask;

   // Frame select idles high so no false frame starts during reset
   dsp_pin_sync #(
      .W         (3),
      .RESET_VAL (3'h1)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .pin_i     ({serial_in_i, serial_clk_i, frame_select_n_i}),
      .level_o   (pins_s)
   );

   dsp_fuse_mem #(
      .PROG_CYCLES (PROG_CYCLES)
   ) u_fuse (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .fuse      (fuse)
   );

   assign fs_n_s = pins_s[0];
   assign sclk_s = pins_s[1];
   assign din_s  = pins_s[2];

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         fs_prev_reg   <= 1'b1;
         sclk_prev_reg <= 1'b0;
      end else begin
         fs_prev_reg   <= fs_n_s;
         sclk_prev_reg <= sclk_s;
      end
   end

   assign fs_fall   = fs_prev_reg && !fs_n_s;
   assign fs_rise   = !fs_prev_reg && fs_n_s;
   // Edges are only looked for inside a frame, so a stopped clock is harmless
   assign sclk_fall = sclk_prev_reg && !sclk_s;

   assign res_mask = LOW_RES ? LOW_RES_MASK : 10'h3FF;

   // Frame state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (fuse.busy) begin
               state_next = ST_LOCK;
            end else if (fs_fall) begin
               state_next = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (fs_rise) begin
               state_next = ST_IDLE;
            end
         end
         ST_LOCK: begin
            // Shift register stays locked until programming ends and no
            // frame is in flight, so a half frame is never picked up
            if (!fuse.busy && fs_n_s) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Bit counting
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         bit_cnt_reg    <= 4'h0;
         full_frame_reg <= 1'b0;
      end else if (state_reg != ST_FRAME) begin
         bit_cnt_reg    <= 4'h0;
         full_frame_reg <= 1'b0;
      end else if (sclk_fall) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         if (bit_cnt_reg == 4'hF) begin
            full_frame_reg <= 1'b1;
         end
      end
   end

   // Short frames and lengths off a 16-bit boundary execute nothing
   assign frame_ok = full_frame_reg && (bit_cnt_reg == 4'h0);
   assign exec     = (state_reg == ST_FRAME) && fs_rise && frame_ok
                     && (shift_reg[15:14] == 2'b00);
   assign cmd      = shift_reg[CMD_MSB:CMD_LSB];
   assign data     = shift_reg[DATA_BITS-1:0];

   // Shift register: capture, daisy chain and readback
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         shift_reg <= 16'h0000;
      end else if (state_reg == ST_FRAME && sclk_fall) begin
         shift_reg <= {shift_reg[14:0], din_s};
      end else if (exec && cmd == CMD_RD_WIPER) begin
         shift_reg <= {6'h00, wiper_reg & res_mask};
      end else if (exec && cmd == CMD_RD_CTRL) begin
         shift_reg <= {12'h000, ctrl_reg};
      end else if (fuse_load_reg) begin
         shift_reg <= {6'h00, fuse.rd_data};
      end
   end

   // Fuse readback takes one cycle for the address to settle
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         rd_addr_reg   <= 5'h00;
         fuse_load_reg <= 1'b0;
      end else begin
         fuse_load_reg <= exec && cmd == CMD_RD_FUSE;
         if (exec && cmd == CMD_RD_FUSE) begin
            rd_addr_reg <= data[FUSE_ADDR_BITS-1:0];
         end
      end
   end

   assign fuse.rd_addr = rd_addr_reg;

   // Wiper register
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         wiper_reg <= WIPER_MIDSCALE;
      end else if (exec) begin
         case (cmd)
            CMD_WR_WIPER: begin
               if (ctrl_reg[CTRL_WR_EN]) begin
                  wiper_reg <= data & res_mask;
               end
            end
            CMD_REFRESH: begin
               wiper_reg <= fuse.last_value;
            end
            default: begin
               wiper_reg <= wiper_reg;
            end
         endcase
      end
   end

   // Control register; the success flag follows the fuse result and clears on a store refused with fuse enable low
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         if (exec && cmd == CMD_WR_CTRL) begin
            ctrl_reg[CTRL_CAL:CTRL_FUSE_EN] <= data[2:0];
         end
         // A completing program reports its result even over a refused store
         if (fuse.done) begin
            ctrl_reg[CTRL_OK] <= fuse.ok;
         end else if (exec && cmd == CMD_STORE && !ctrl_reg[CTRL_FUSE_EN]) begin
            ctrl_reg[CTRL_OK] <= 1'b0;
         end
      end
   end

   // Shutdown state
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         shutdown_reg <= 1'b0;
      end else if (exec && cmd == CMD_SHUTDOWN) begin
         shutdown_reg <= data[0];
      end
   end

   // Store request to the fuse memory
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         store_reg      <= 1'b0;
         store_data_reg <= 10'h000;
      end else begin
         store_reg <= exec && cmd == CMD_STORE && ctrl_reg[CTRL_FUSE_EN];
         if (exec && cmd == CMD_STORE) begin
            store_data_reg <= wiper_reg & res_mask;
         end
      end
   end

   assign fuse.store      = store_reg;
   assign fuse.store_data = store_data_reg;

   // Open-drain pins: drive low only when the line must read zero
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         dout_oe_n_reg  <= 1'b1;
         ready_oe_n_reg <= 1'b1;
      end else begin
         dout_oe_n_reg  <= !(!fs_n_s && !shift_reg[15]);
         ready_oe_n_reg <= !(fuse.busy || store_reg);
      end
   end

   assign serial_out_o         = 1'b0;
   assign serial_out_oe_n_o    = dout_oe_n_reg;
   assign ready_o              = 1'b0;
   assign ready_oe_n_o         = ready_oe_n_reg;
   assign wiper_position_o     = wiper_reg;
   assign control_flags_o      = ctrl_reg;
   assign shutdown_o           = shutdown_reg;
   assign calibration_select_o = ctrl_reg[CTRL_CAL];
endmodule

// >>> dsp_host_model.sv
/*
 Host-side serial master model for the command port pins.
 Assumes the bench clock and a serial out level already resolved with its pull-up.
*/
`timescale 1ns/1ps
module dsp_host_model (
   input  wire logic clk_sys_i,
   input  wire logic serial_out_i,
   output logic      frame_select_n_o,
   output logic      serial_clk_o,
   output logic      serial_in_o
);
   initial begin
      frame_select_n_o = 1'b1;
      serial_clk_o     = 1'b0;
      serial_in_o      = 1'b0;
   end

   // Clock idles low and stops between frames, so no stray falling edge is seen
   task automatic xfer(input logic [31:0] word, input int nbits, output logic [31:0] rx);
      rx = '0;
      @(negedge clk_sys_i);
      frame_select_n_o = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      for (int i = nbits - 1; i >= 0; i--) begin
         serial_in_o  = word[i];
         serial_clk_o = 1'b1;
         repeat (4) @(negedge clk_sys_i);
         rx           = {rx[30:0], serial_out_i};
         serial_clk_o = 1'b0;
         repeat (4) @(negedge clk_sys_i);
      end
      frame_select_n_o = 1'b1;
      // Data line flips once idle so a stale bit is never mistaken for a held one
      serial_in_o      = ~serial_in_o;
      repeat (8) @(negedge clk_sys_i);
   endtask
endmodule

// >>> dsp_serial_port_props.sv
/*
 Concurrent checks on the command port top-level pins.
 Assumes it is bound to dsp_serial_port and shares its PROG_CYCLES.
*/
`timescale 1ns/1ps
module dsp_serial_port_props
   import dsp_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = FUSE_PROG_CYCLES
) (
   input wire logic       clk_sys_i,
   input wire logic       reset_n_i,
   input wire logic       frame_select_n_i,
   input wire logic       serial_out_o,
   input wire logic       serial_out_oe_n_o,
   input wire logic       ready_o,
   input wire logic       ready_oe_n_o,
   input wire logic [9:0] wiper_position_o,
   input wire logic [3:0] control_flags_o,
   input wire logic       shutdown_o,
   input wire logic       calibration_select_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   logic [31:0] busy_cnt_reg;
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i || ready_oe_n_o) begin
         busy_cnt_reg <= 32'h0;
      end else begin
         busy_cnt_reg <= busy_cnt_reg + 32'h1;
      end
   end

   sequence s_fs_idle;
      frame_select_n_i [*6];
   endsequence
   // Register updates only land a few cycles after frame select has risen
   sequence s_settled;
      $past(frame_select_n_i, 1) && $past(frame_select_n_i, 3);
   endsequence
   // A store refused on a full memory only blinks ready and reports failure
   sequence s_prog_end;
      $rose(ready_oe_n_o) && busy_cnt_reg > 32'h2;
   endsequence

   property p_pins_low;
      serial_out_o == 1'b0 && ready_o == 1'b0;
   endproperty
   a_pins_low: assert property (p_pins_low) else $error("open-drain data not low");
   property p_sdo_release;
      s_fs_idle |-> serial_out_oe_n_o;
   endproperty
   a_sdo_release: assert property (p_sdo_release) else $error("serial out driven idle");
   property p_wiper_idle;
      $changed(wiper_position_o) |-> s_settled;
   endproperty
   a_wiper_idle: assert property (p_wiper_idle) else $error("wiper moved in frame");
   property p_ctrl_idle;
      $changed(control_flags_o) |-> s_settled;
   endproperty
   a_ctrl_idle: assert property (p_ctrl_idle) else $error("control moved in frame");
   property p_shdn_idle;
      $changed(shutdown_o) |-> s_settled;
   endproperty
   a_shdn_idle: assert property (p_shdn_idle) else $error("shutdown moved in frame");
   property p_cal_mirror;
      $stable(control_flags_o) |-> calibration_select_o == control_flags_o[CTRL_CAL];
   endproperty
   a_cal_mirror: assert property (p_cal_mirror) else $error("calibration mismatch");
   property p_busy_bound;
      busy_cnt_reg <= PROG_CYCLES + 4;
   endproperty
   a_busy_bound: assert property (p_busy_bound) else $error("ready low too long");
   property p_prog_ok;
      s_prog_end |-> ##[0:2] control_flags_o[CTRL_OK];
   endproperty
   a_prog_ok: assert property (p_prog_ok) else $error("program ok flag missing");
   property p_lock;
      !ready_oe_n_o |=> $stable(wiper_position_o);
   endproperty
   a_lock: assert property (p_lock) else $error("wiper moved while locked");
   property p_reset_vals;
      disable iff (1'b0)
      !reset_n_i |=> wiper_position_o == WIPER_MIDSCALE && control_flags_o == CTRL_RESET
                     && !shutdown_o && serial_out_oe_n_o && ready_oe_n_o;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
endmodule

bind dsp_serial_port dsp_serial_port_props #(.PROG_CYCLES(PROG_CYCLES)) u_dsp_serial_port_props (
   .clk_sys_i            (clk_sys_i),
   .reset_n_i            (reset_n_i),
   .frame_select_n_i     (frame_select_n_i),
   .serial_out_o         (serial_out_o),
   .serial_out_oe_n_o    (serial_out_oe_n_o),
   .ready_o              (ready_o),
   .ready_oe_n_o         (ready_oe_n_o),
   .wiper_position_o     (wiper_position_o),
   .control_flags_o      (control_flags_o),
   .shutdown_o           (shutdown_o),
   .calibration_select_o (calibration_select_o)
);

// >>> dsp_serial_port_test.sv
/*
 Self-checking bench for the command port, driven through the host model.
 Assumes a shortened program time and pull-ups on both open-drain pins.
*/
`timescale 1ns/1ps
module dsp_serial_port_test
   import dsp_pkg::*;
();
   localparam int PROG = 20;
   logic        clk;
   logic        rst_n;
   logic        fs_n;
   logic        sclk;
   logic        din;
   logic        dout;
   logic        dout_oe_n;
   logic        rdy;
   logic        rdy_oe_n;
   logic [9:0]  wiper;
   logic [3:0]  ctrl;
   logic        shdn;
   logic        cal;
   logic        dout_w;
   logic        rdy_w;
   logic [31:0] rx;
   int          err_total;
   int          cmp_count;

   assign dout_w = dout_oe_n ? 1'b1 : dout;
   assign rdy_w = rdy_oe_n ? 1'b1 : rdy;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   dsp_serial_port #(.PROG_CYCLES(PROG)) u_dsp_serial_port (
      .clk_sys_i(clk), .reset_n_i(rst_n), .frame_select_n_i(fs_n),
      .serial_clk_i(sclk), .serial_in_i(din), .serial_out_i(dout_w),
      .serial_out_o(dout), .serial_out_oe_n_o(dout_oe_n), .ready_i(rdy_w),
      .ready_o(rdy), .ready_oe_n_o(rdy_oe_n), .wiper_position_o(wiper),
      .control_flags_o(ctrl), .shutdown_o(shdn), .calibration_select_o(cal));

   dsp_host_model u_dsp_host_model (
      .clk_sys_i(clk), .serial_out_i(dout_w), .frame_select_n_o(fs_n),
      .serial_clk_o(sclk), .serial_in_o(din));

   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_regs(input logic [9:0] w, input logic [3:0] c, input logic s);
      chk("wiper", {6'h0, w}, {6'h0, wiper});
      chk("ctrl", {12'h0, c}, {12'h0, ctrl});
      chk("shutdown", {15'h0, s}, {15'h0, shdn});
   endtask

   task automatic send(input logic [3:0] cmd, input logic [9:0] data);
      u_dsp_host_model.xfer({18'h0, cmd, data}, 16, rx);
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (rdy_w !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 10 * PROG) begin
            err_total++;
            $display("[ERR] ready expected 1 seen %b", rdy_w);
            tally_and_finish();
         end
      end
   endtask

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   // Narrow variant drops the two wiper LSBs
   function automatic logic [9:0] mask_w(input logic [9:0] v);
      return LOW_RES ? (v & LOW_RES_MASK) : v;
   endfunction

   initial begin
      logic [9:0] v;
      err_total = 0;
      cmp_count = 0;
      do_reset();
      chk_regs(WIPER_MIDSCALE, CTRL_RESET, 1'b0);
      send(CMD_WR_WIPER, 10'h155);
      chk_regs(WIPER_MIDSCALE, CTRL_RESET, 1'b0);
      send(CMD_WR_CTRL, 10'h3FE);
      chk_regs(WIPER_MIDSCALE, 4'h6, 1'b0);
      chk("cal", 16'h0001, {15'h0, cal});
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'h155;
         send(CMD_WR_WIPER, v);
         chk("wiper", {6'h0, mask_w(v)}, {6'h0, wiper});
      end
      send(CMD_RD_WIPER, 10'h000);
      send(CMD_NO_OPERATION, 10'h3FF);
      chk("rd_wiper", 16'h0155, {6'h0, rx[9:0]});
      chk_regs(10'h155, 4'h6, 1'b0);
      send(CMD_RD_CTRL, 10'h000);
      send(CMD_NO_OPERATION, 10'h000);
      chk("rd_ctrl", 16'h0006, {12'h0, rx[3:0]});
      u_dsp_host_model.xfer({18'h0, CMD_WR_WIPER, 10'h0AA}, 15, rx);
      chk_regs(10'h155, 4'h6, 1'b0);
      u_dsp_host_model.xfer({16'h0, 2'b01, CMD_WR_WIPER, 10'h0AA}, 16, rx);
      chk_regs(10'h155, 4'h6, 1'b0);
      for (int c = 9; c < 16; c++) begin
         send(4'(c), 10'h3FF);
         chk_regs(10'h155, 4'h6, 1'b0);
      end
      send(CMD_SHUTDOWN, 10'h001);
      chk("shutdown", 16'h0001, {15'h0, shdn});
      send(CMD_SHUTDOWN, 10'h3FE);
      chk("shutdown", 16'h0000, {15'h0, shdn});
      send(CMD_STORE, 10'h000);
      chk("ready", 16'h0001, {15'h0, rdy_w});
      chk("ctrl", 16'h0006, {12'h0, ctrl});
      send(CMD_WR_CTRL, 10'h007);
      send(CMD_STORE, 10'h000);
      chk("ready", 16'h0000, {15'h0, rdy_w});
      wait_ready();
      chk("ctrl", 16'h000F, {12'h0, ctrl});
      // One location used: one ones-bit in the low status word, none in the high
      send(CMD_RD_FUSE, 10'h014);
      send(CMD_RD_FUSE, 10'h015);
      chk("rd_status_lo", 16'h0001, {6'h0, rx[9:0]});
      // Upper data bits are don't care, location zero selected
      send(CMD_RD_FUSE, 10'h3E0);
      chk("rd_status_hi", 16'h0000, {6'h0, rx[9:0]});
      send(CMD_NO_OPERATION, 10'h000);
      chk("rd_fuse", 16'h0155, {6'h0, rx[9:0]});
      send(CMD_WR_WIPER, 10'h0AA);
      chk("wiper", 16'h00AA, {6'h0, wiper});
      send(CMD_REFRESH, 10'h000);
      chk("wiper", 16'h0155, {6'h0, wiper});
      u_dsp_host_model.xfer({16'h2AB5, 2'b00, CMD_WR_WIPER, 10'h2F0}, 32, rx);
      chk("chain", 16'h2AB5, rx[15:0]);
      chk("wiper", 16'h02F0, {6'h0, wiper});
      do_reset();
      chk_regs(WIPER_MIDSCALE, CTRL_RESET, 1'b0);
      tally_and_finish();
   end
endmodule
